// ===== pkg/tiq_pkg.sv
// Purpose: Shared constants and carrier types for the timer 0 interrupt mask and flag block.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   Offsets are word indices; the byte address is four times the index.
package tiq_pkg;

	// The enable index is not a multiple of four, so it cannot be used as a byte address.
	// The flag index is placed next to it.
	localparam logic [11:0] TIQ_OFF_ENABLE = 12'h06E;
	localparam logic [11:0] TIQ_OFF_FLAGS  = 12'h06F;
	localparam int          TIQ_OVF_BIT    = 0;
	localparam int          TIQ_CMPA_BIT   = 1;
	localparam int          TIQ_CMPB_BIT   = 2;
	localparam int          TIQ_NSRC       = 3;
	localparam logic [2:0]  TIQ_ENABLE_RST = 3'h0;
	localparam logic [2:0]  TIQ_FLAGS_RST  = 3'h0;
	localparam logic [7:0]  TIQ_MAX        = 8'hFF;
	localparam logic [7:0]  TIQ_BOTTOM     = 8'h00;

	typedef enum logic [2:0] {
		TIQ_WGM_NORMAL    = 3'h0,
		TIQ_WGM_PC_FF     = 3'h1,
		TIQ_WGM_CTC       = 3'h2,
		TIQ_WGM_FAST_FF   = 3'h3,
		TIQ_WGM_RSVD4     = 3'h4,
		TIQ_WGM_PC_OCRA   = 3'h5,
		TIQ_WGM_RSVD6     = 3'h6,
		TIQ_WGM_FAST_OCRA = 3'h7
	} tiq_wgm_t;

	typedef struct packed {
		logic            penable;
		logic            pwrite;
		logic [11:0]     paddr;
		logic [31:0]     pwdata;
	} tiq_apb_req_t;

	typedef struct packed {
		logic [7:0]      timer_count;
		logic [7:0]      compare_a_value;
		logic [7:0]      compare_b_value;
		tiq_wgm_t        waveform_mode_sel;
		logic            count_tick;
	} tiq_timer_t;

endpackage : tiq_pkg

// ===== design/tiq_event_detect.sv
// Purpose: Turns the timer's count state into one-cycle overflow and compare events.
// Assumes: count_tick pulses on the cycle the counter takes its new value.
// Notes:   Forced compare strobes never reach this module, so they raise no flag.
`timescale 1ns/1ns
`default_nettype none
module tiq_event_detect
	import tiq_pkg::*;
(
	input  wire logic              clk_i,   // System clock.
	input  wire logic              rst_b_i, // Asynchronous reset, active low.
	input  wire tiq_timer_t        tmr_i,   // Timer state.
	output logic [TIQ_NSRC-1:0]    evt_o    // One-cycle event pulses.
);

	typedef struct packed {
		logic [TIQ_NSRC-1:0] evt;
	} tiq_det_state_t;

	tiq_det_state_t st_q;
	tiq_det_state_t st_d;
	logic           ovf_hit;

	always_comb begin
		ovf_hit = 1'b0;
		case (tmr_i.waveform_mode_sel)
			TIQ_WGM_NORMAL, TIQ_WGM_CTC, TIQ_WGM_FAST_FF: begin
				ovf_hit = (tmr_i.timer_count == TIQ_MAX);
			end
			TIQ_WGM_PC_FF, TIQ_WGM_PC_OCRA: begin
				ovf_hit = (tmr_i.timer_count == TIQ_BOTTOM);
			end
			TIQ_WGM_FAST_OCRA: begin
				ovf_hit = (tmr_i.timer_count == tmr_i.compare_a_value);
			end
			default: begin
				ovf_hit = 1'b0;
			end
		endcase
		st_d                   = st_q;
		st_d.evt               = '0;
		st_d.evt[TIQ_OVF_BIT]  = tmr_i.count_tick & ovf_hit;
		st_d.evt[TIQ_CMPA_BIT] = tmr_i.count_tick & (tmr_i.timer_count == tmr_i.compare_a_value);
		st_d.evt[TIQ_CMPB_BIT] = tmr_i.count_tick & (tmr_i.timer_count == tmr_i.compare_b_value);
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign evt_o = st_q.evt;

endmodule : tiq_event_detect
`default_nettype wire

// ===== design/tiq_irq_top.sv
// Purpose: Interrupt enable and flag registers of timer 0 with per-source requests.
// Assumes: APB slave, zero wait states; CPU gives a one-cycle vector acknowledge per source.
// Notes:   A flag event beats a clear arriving in the same cycle.
`timescale 1ns/1ns
`default_nettype none

module tiq_irq_top
	import tiq_pkg::*;
(
	input  wire logic                 CLK_SYS_I,     // 100 MHz system clock.
	input  wire logic                 RST_B_I,       // Asynchronous reset, active low.
	input  wire logic                 PSEL_I,        // APB select.
	input  wire logic                 PENABLE_I,     // APB enable.
	input  wire logic                 PWRITE_I,      // APB write.
	input  wire logic [11:0]          PADDR_I,       // APB byte address.
	input  wire logic [31:0]          PWDATA_I,      // APB write data.
	output logic [31:0]               PRDATA_O,      // APB read data.
	output logic                      PREADY_O,      // APB ready.
	output logic                      PSLVERR_O,     // APB error, unmapped address.
	input  wire tiq_timer_t           TIMER_I,       // Timer count state, same clock.
	input  wire logic                 FORCE_CMP_A_STROBE_I, // Forced compare A strobe.
	input  wire logic                 GLOBAL_IRQ_EN_I, // CPU global interrupt bit.
	input  wire logic [TIQ_NSRC-1:0]  VEC_ACK_I,     // Vector acknowledge pulses.
	output logic [TIQ_NSRC-1:0]       IRQ_REQ_O,     // Per-source requests.
	output logic                      IRQ_O          // Combined level interrupt.
);

	typedef struct packed {
		logic [TIQ_NSRC-1:0] enable;
		logic [TIQ_NSRC-1:0] flags;
		logic [TIQ_NSRC-1:0] req;
		logic                irq;
		logic [31:0]         prdata;
		logic                pready;
		logic                pslverr;
	} tiq_top_state_t;

	tiq_top_state_t       st_q;
	tiq_top_state_t       st_d;
	logic [TIQ_NSRC-1:0]  evt;
	logic                 setup;
	logic                 hit_en;
	logic                 hit_fl;
	logic [TIQ_NSRC-1:0]  sw_clr;

	// The forced strobe is kept away from event detection on purpose.
	tiq_event_detect u_detect (
		.clk_i   (CLK_SYS_I),
		.rst_b_i (RST_B_I),
		.tmr_i   (TIMER_I),
		.evt_o   (evt)
	);

	always_comb begin
		st_d    = st_q;
		setup   = PSEL_I & ~PENABLE_I;
		hit_en  = (PADDR_I[11:2] == TIQ_OFF_ENABLE[9:0]) && (PADDR_I[1:0] == 2'h0);
		hit_fl  = (PADDR_I[11:2] == TIQ_OFF_FLAGS[9:0]) && (PADDR_I[1:0] == 2'h0);
		sw_clr  = '0;
		st_d.pready  = 1'b0;
		st_d.pslverr = 1'b0;
		st_d.prdata  = '0;
		if (setup) begin
			st_d.pready  = 1'b1;
			st_d.pslverr = ~(hit_en | hit_fl);
			if (PWRITE_I) begin
				if (hit_en) begin
					st_d.enable = PWDATA_I[TIQ_NSRC-1:0];
				end
				if (hit_fl) begin
					sw_clr = PWDATA_I[TIQ_NSRC-1:0];
				end
			end else if (hit_en) begin
				st_d.prdata[TIQ_NSRC-1:0] = st_q.enable;
			end else if (hit_fl) begin
				st_d.prdata[TIQ_NSRC-1:0] = st_q.flags;
			end
		end
		// Set beats clear so a match in the clearing cycle is not lost.
		st_d.flags = (st_q.flags & ~(sw_clr | VEC_ACK_I)) | evt;
		st_d.req   = st_d.flags & st_d.enable & {TIQ_NSRC{GLOBAL_IRQ_EN_I}};
		st_d.irq   = |(st_d.flags & st_d.enable);
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			st_q        <= '0;
			st_q.enable <= TIQ_ENABLE_RST;
			st_q.flags  <= TIQ_FLAGS_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign PRDATA_O  = st_q.prdata;
	assign PREADY_O  = st_q.pready;
	assign PSLVERR_O = st_q.pslverr;
	assign IRQ_REQ_O = st_q.req;
	assign IRQ_O     = st_q.irq;

endmodule : tiq_irq_top
`default_nettype wire

// ===== tb/tiq_monitor.sv
// Purpose: Port assertions for the timer 0 interrupt block.
// Assumes: Flags and requests are registered from one next value.
// Notes:   A tick one cycle before a clear re-sets the flag, so it is excluded.
`timescale 1ns/1ns
`default_nettype none
module tiq_monitor
	import tiq_pkg::*;
(
	input wire logic CLK_SYS_I, RST_B_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, GLOBAL_IRQ_EN_I, IRQ_O,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I, PRDATA_O,
	input wire tiq_timer_t  TIMER_I,
	input wire logic [2:0]  VEC_ACK_I, IRQ_REQ_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_B_I);
	wire wr_f = PSEL_I && !PENABLE_I && PWRITE_I && PADDR_I == {TIQ_OFF_FLAGS[9:0], 2'h0};
	property p_gi(int k);
		IRQ_REQ_O[k] |-> $past(GLOBAL_IRQ_EN_I);
	endproperty
	property p_ack(int k);
		VEC_ACK_I[k] && !$past(TIMER_I.count_tick) |=> !IRQ_REQ_O[k];
	endproperty
	a_rsvd_zero: assert property (PREADY_O |-> PRDATA_O[31:3] == '0) else $error("reserved set");
	a_req_b_gi: assert property (p_gi(2)) else $error("b request ungated");
	a_req_a_gi: assert property (p_gi(1)) else $error("a request ungated");
	a_req_ovf_gi: assert property (p_gi(0)) else $error("ovf request ungated");
	a_ack_b_clr: assert property (p_ack(2)) else $error("b ack kept");
	a_ack_a_clr: assert property (p_ack(1)) else $error("a ack kept");
	a_ack_ovf_clr: assert property (p_ack(0)) else $error("ovf ack kept");
	a_w1c_clr: assert property (wr_f && !$past(TIMER_I.count_tick) |=> (IRQ_REQ_O & $past(PWDATA_I[2:0])) == '0)
		else $error("w1c kept");
	a_irq_any: assert property (|IRQ_REQ_O |-> IRQ_O) else $error("irq low");
endmodule : tiq_monitor
`default_nettype wire

// ===== tb/tiq_cpu_model.sv
// Purpose: CPU side that takes requests and pulses vector acknowledges.
// Assumes: Lowest pending source is served first.
// Notes:   A gap cycle lets the clear land before the next acknowledge.
`timescale 1ns/1ns
`default_nettype none
module tiq_cpu_model
	import tiq_pkg::*;
(
	input  wire logic                clk_i,   // Clock.
	input  wire logic                rst_b_i, // Reset, active low.
	input  wire logic                take_i,  // Accept requests.
	input  wire logic [TIQ_NSRC-1:0] req_i,   // Requests.
	output logic [TIQ_NSRC-1:0]      ack_o    // Acknowledges.
);
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) ack_o <= '0;
		else ack_o <= (take_i && ack_o == '0) ? req_i & (~req_i + 3'h1) : '0;
	end
endmodule : tiq_cpu_model
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Register, flag and request tests of the timer 0 interrupt block.
// Assumes: Zero-wait APB slave.
// Notes:   Compare values stay fixed at 0x40 and 0x80.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import tiq_pkg::*;
	logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, frc = 0, gl = 0, take = 0, rdy, slv, irq, se;
	logic [11:0] padr = '0;
	logic [31:0] pwd = '0, prd, e;
	logic [2:0] ack, req;
	logic [7:0] cnt [4] = '{8'hFF, 8'h00, 8'h40, 8'h80};
	tiq_timer_t tmr = '{8'h00, 8'h40, 8'h80, TIQ_WGM_NORMAL, 1'b0};
	int err_total = 0, n_checks = 0, cyc = 0;
	always #5 clk = ~clk;
	tiq_irq_top u_tiq_irq_top (.CLK_SYS_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(slv), .TIMER_I(tmr),
		.FORCE_CMP_A_STROBE_I(frc), .GLOBAL_IRQ_EN_I(gl), .VEC_ACK_I(ack), .IRQ_REQ_O(req), .IRQ_O(irq));
	tiq_cpu_model u_tiq_cpu_model (.clk_i(clk), .rst_b_i(rst_b), .take_i(take), .req_i(req), .ack_o(ack));
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", s, x, g);
		end
	endtask : chk
	task automatic io(input logic w, input logic [11:0] a, input logic [31:0] d, input string s = "");
		@(posedge clk) {psel, pen, pwr, padr, pwd} <= {2'b10, w, a[9:0], 2'b00, d};
		@(posedge clk) pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		if (!w) chk(s, d, prd);
		se = slv;
		{psel, pen} <= 2'b00;
	endtask : io
	task automatic ev(input logic [7:0] c);
		@(posedge clk) {tmr.timer_count, tmr.count_tick} <= {c, 1'b1};
		@(posedge clk) tmr.count_tick <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : ev
	function automatic logic ovf_at(input int m, input logic [7:0] c);
		case (m)
			0, 2, 3: return c == TIQ_MAX;
			1, 5: return c == TIQ_BOTTOM;
			7: return c == 8'h40;
			default: return 1'b0;
		endcase
	endfunction : ovf_at
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			err_total++;
			wrap_up();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		io(0, TIQ_OFF_ENABLE, 32'h0, "enable reset");
		io(0, TIQ_OFF_FLAGS, 32'h0, "flags reset");
		io(1, TIQ_OFF_ENABLE, 32'hFFFFFFFF);
		io(0, TIQ_OFF_ENABLE, 32'h7, "enable rsvd");
		chk("slverr mapped", 32'h0, se);
		io(0, 12'h100, 32'h0, "unmapped");
		chk("slverr unmapped", 32'h1, se);
		for (int m = 0; m < 8; m++) for (int i = 0; i < 4; i++) begin
			io(1, TIQ_OFF_FLAGS, 32'h7);
			tmr.waveform_mode_sel <= tiq_wgm_t'(m);
			ev(cnt[i]);
			e = {29'h0, cnt[i] == 8'h80, cnt[i] == 8'h40, ovf_at(m, cnt[i])};
			io(0, TIQ_OFF_FLAGS, e, "flags per mode");
			chk("lines gated", {|e, 3'h0}, {irq, req});
		end
		gl <= 1'b1;
		io(0, TIQ_OFF_FLAGS, 32'h4, "flags b");
		chk("req b", 32'h4, req);
		ev(8'h40);
		chk("req all", 32'h7, req);
		io(1, TIQ_OFF_ENABLE, 32'h0);
		chk("masked", 32'h0, {irq, req});
		io(1, TIQ_OFF_FLAGS, 32'h5);
		io(0, TIQ_OFF_FLAGS, 32'h2, "w1c");
		io(1, TIQ_OFF_ENABLE, 32'h7);
		take <= 1'b1;
		ev(8'h80);
		frc <= 1'b1;
		repeat (10) @(posedge clk) frc <= 1'b0;
		io(0, TIQ_OFF_FLAGS, 32'h0, "acked");
		wrap_up();
	end
endmodule : tb_top
bind tiq_irq_top tiq_monitor u_tiq_monitor (.CLK_SYS_I(CLK_SYS_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PREADY_O(PREADY_O), .GLOBAL_IRQ_EN_I(GLOBAL_IRQ_EN_I),
	.IRQ_O(IRQ_O), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .TIMER_I(TIMER_I),
	.VEC_ACK_I(VEC_ACK_I), .IRQ_REQ_O(IRQ_REQ_O));
`default_nettype wire
